/* verilog/cap_pkg.sv */
// Purpose: Constants for the counter array with 16-bit PWM and flag tree
// Assumes: AHB-Lite word registers, byte address = index * 4
// Notes:
// Functional notes
// - Idle suspend bit halts first array counting while the CPU idles.
// - Watchdog enable makes compare module 5 the watchdog; here it drives watchdog_active and freezes the other mode bits, and module 5 is unchanged.
// - Watchdog lock forbids clearing watchdog enable until reset.
// - Mode bit 4 reads zero; writes to it are ignored.
// - Timebase select picks sysclk/12, /4, timer 0, sysclk, timer 4, 5.
// - Code 011 counts falling edges of external count input, max sysclk/4.
// - Code 101 counts external oscillator divided by 8, resynchronised.
// - Overflow interrupt enable gates the first array overflow flag.
// - While watchdog enabled, other mode bits cannot change.
// - Second array sets overflow flag on 16-bit counter overflow.
// - Intermediate overflow flag set on overflow of bit 8, 9, 10 or 11.
// - Overflow and intermediate flags set on their trigger regardless of enables; channel flags need enables.
// - Each flag has its own enable; only enabled flags request.
// - Second array request needs global and array gates both set.
// - Wide PWM pin goes high on compare match, low on overflow.
// - Wide PWM needs comparator, PWM and wide select bits all set.
// - With match flag enable, channel flag sets on every match while in wide PWM mode.
// - Low byte write clears comparator enable; high byte write sets it.
// - High fraction is (65536 - compare)/65536; zero means always high.
// - Cleared comparator enable holds PWM output low.
package cap_pkg;
   localparam logic [7:0] IDX_MODE     = 8'hd9;
   localparam logic [7:0] IDX_A1CTL    = 8'hd8;
   localparam logic [7:0] IDX_A1CNT    = 8'hda;
   localparam logic [7:0] IDX_A2CTL    = 8'he0;
   localparam logic [7:0] IDX_A2IE     = 8'he1;
   localparam logic [7:0] IDX_A2CNT    = 8'he2;
   localparam logic [7:0] IDX_CHMODE   = 8'he8;
   localparam logic [7:0] IDX_CMPL     = 8'hf0;
   localparam logic [7:0] IDX_CMPH     = 8'hf8;
   localparam int         NCH          = 6;
   localparam logic [7:0] MODE_RESET   = 8'h40;
   localparam logic [7:0] MODE_MASK    = 8'hef;
   localparam int         MD_IDLE      = 7;
   localparam int         MD_WDE       = 6;
   localparam int         MD_WDL       = 5;
   localparam int         MD_TBS       = 1;
   localparam int         MD_OIE       = 0;
   localparam int         C1_FLAG      = 7;
   localparam int         C1_RUN       = 6;
   localparam int         C2_IM        = 6;
   localparam int         C2_OVF       = 7;
   localparam int         C2_RUN       = 8;
   localparam int         C2_SEL       = 9;
   localparam int         IE_IM        = 6;
   localparam int         IE_OVF       = 7;
   localparam int         IE_GATE      = 8;
   localparam int         IE_GLOBAL    = 9;
   localparam int         MM_CMP_EN    = 0;
   localparam int         MM_PWM_EN    = 1;
   localparam int         MM_WIDE      = 2;
   localparam int         MM_MATCH     = 3;
   localparam int         IM_BASE_BIT  = 8;
   localparam int         DIV_SLOW     = 12;
   localparam int         DIV_FAST     = 4;
   localparam int         EXT_DIV      = 8;
   localparam logic [2:0] TB_DIV12     = 3'h0;
   localparam logic [2:0] TB_DIV4      = 3'h1;
   localparam logic [2:0] TB_T0        = 3'h2;
   localparam logic [2:0] TB_ECI       = 3'h3;
   localparam logic [2:0] TB_SYS       = 3'h4;
   localparam logic [2:0] TB_EXT       = 3'h5;
   localparam logic [2:0] TB_T4        = 3'h6;
   localparam logic [2:0] TB_T5        = 3'h7;
endpackage : cap_pkg

/* verilog/cap_top.sv */
// Purpose: Counter array, mode register, second array flags and wide PWM
// Assumes: Single AHB-Lite master, word transfers only, zero wait states
// Notes: Watchdog timing itself lives outside; only its enable is here
`timescale 1ns/100ps
module cap_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic [31:0] hrdata,
   output      logic        hresp,
   input  wire logic        cpu_idle,
   input  wire logic        timer0_ovf,
   input  wire logic        timer4_ovf,
   input  wire logic        timer5_ovf,
   input  wire logic        external_count_input,
   input  wire logic        ext_osc,
   output      logic        array1_irq,
   output      logic        array2_irq,
   output      logic        watchdog_active,
   output      logic [5:0]  channel_output_pin
);
   import cap_pkg::*;

   typedef struct packed {
      logic [7:0]  mode;
      logic        a1_run;
      logic        a1_flag;
      logic [15:0] a1_cnt;
      logic [3:0]  pre_slow;
      logic [1:0]  pre_fast;
      logic [1:0]  eci_s;
      logic        eci_d;
      logic [1:0]  xo_s;
      logic        xo_d;
      logic [2:0]  xo_div;
      logic        a2_run;
      logic        a2_flag;
      logic        im_flag;
      logic [5:0]  ch_flag;
      logic [1:0]  im_sel;
      logic [15:0] a2_cnt;
      logic [9:0]  ie;
      logic [23:0] ch_mode;
      logic [95:0] cmp;
      logic [5:0]  pin;
      logic        wr_pend;
      logic [7:0]  idx;
      logic [31:0] rdata;
   } cap_state_type;

   cap_state_type s_reg;
   cap_state_type s_next;

   logic        acc;
   logic [7:0]  a_idx;
   logic [5:0]  ch_active;
   logic [15:0] a2_nx;
   logic        a2_wrap;
   logic [15:0] im_mask;
   logic        a1_src;
   logic        a1_go;

   assign acc   = hsel & htrans[1] & hready & (hsize == 3'h2);
   assign a_idx = haddr[9:2];

   function automatic logic [31:0] rd_word(input cap_state_type s,
                                           input logic [7:0] i);
      logic [7:0] k;
      rd_word = 32'h0;
      k = 8'h0;
      if (i == IDX_MODE)
         rd_word = {24'h0, s.mode & MODE_MASK};
      else if (i == IDX_A1CTL)
         rd_word = {24'h0, s.a1_flag, s.a1_run, 6'h0};
      else if (i == IDX_A1CNT)
         rd_word = {16'h0, s.a1_cnt};
      else if (i == IDX_A2CTL)
         rd_word = {21'h0, s.im_sel, s.a2_run, s.a2_flag, s.im_flag,
                    s.ch_flag};
      else if (i == IDX_A2IE)
         rd_word = {22'h0, s.ie};
      else if (i == IDX_A2CNT)
         rd_word = {16'h0, s.a2_cnt};
      else if (i >= IDX_CHMODE && i < IDX_CHMODE + 8'(NCH)) begin
         k = i - IDX_CHMODE;
         rd_word = {28'h0, s.ch_mode[4*k +: 4]};
      end else if (i >= IDX_CMPL && i < IDX_CMPL + 8'(NCH)) begin
         k = i - IDX_CMPL;
         rd_word = {24'h0, s.cmp[16*k +: 8]};
      end else if (i >= IDX_CMPH && i < IDX_CMPH + 8'(NCH)) begin
         k = i - IDX_CMPH;
         rd_word = {24'h0, s.cmp[16*k+8 +: 8]};
      end
   endfunction : rd_word

   // Wide PWM qualifies per channel
   for (genvar g = 0; g < NCH; g++) begin : g_act
      assign ch_active[g] = s_reg.ch_mode[4*g+MM_CMP_EN]
                          & s_reg.ch_mode[4*g+MM_PWM_EN]
                          & s_reg.ch_mode[4*g+MM_WIDE];
   end

   assign a2_nx   = s_reg.a2_cnt + 16'h1;
   assign a2_wrap = s_reg.a2_run & (s_reg.a2_cnt == 16'hffff);
   assign im_mask = 16'((32'h1 << (IM_BASE_BIT + int'(s_reg.im_sel))) - 1);

   always_comb begin
      case (s_reg.mode[MD_TBS +: 3])
         TB_DIV12: a1_src = (s_reg.pre_slow == 4'(DIV_SLOW - 1));
         TB_DIV4:  a1_src = (s_reg.pre_fast == 2'(DIV_FAST - 1));
         TB_T0:    a1_src = timer0_ovf;
         TB_ECI:   a1_src = s_reg.eci_d & ~s_reg.eci_s[1];
         TB_SYS:   a1_src = 1'b1;
         TB_EXT:   a1_src = s_reg.xo_d & ~s_reg.xo_s[1]
                            & (s_reg.xo_div == 3'(EXT_DIV - 1));
         TB_T4:    a1_src = timer4_ovf;
         TB_T5:    a1_src = timer5_ovf;
         default:  a1_src = 1'b0;
      endcase
   end

   // Idle only freezes the count; bus access keeps working
   assign a1_go = s_reg.a1_run & a1_src
                & ~(s_reg.mode[MD_IDLE] & cpu_idle);

   always_comb begin
      logic [7:0]  k;
      logic [31:0] wd;
      s_next = s_reg;
      k = 8'h0;
      wd = hwdata;
      s_next.pre_slow = (s_reg.pre_slow == 4'(DIV_SLOW - 1))
                      ? 4'h0 : s_reg.pre_slow + 4'h1;
      s_next.pre_fast = s_reg.pre_fast + 2'h1;
      s_next.eci_s = {s_reg.eci_s[0], external_count_input};
      s_next.eci_d = s_reg.eci_s[1];
      s_next.xo_s  = {s_reg.xo_s[0], ext_osc};
      s_next.xo_d  = s_reg.xo_s[1];
      if (s_reg.xo_d & ~s_reg.xo_s[1])
         s_next.xo_div = s_reg.xo_div + 3'h1;
      // Bus write first, so hardware sets below win over a clear
      if (s_reg.wr_pend) begin
         if (s_reg.idx == IDX_MODE) begin
            if (s_reg.mode[MD_WDE]) begin
               if (!s_reg.mode[MD_WDL])
                  s_next.mode[MD_WDE] = wd[MD_WDE];
            end else begin
               s_next.mode = wd[7:0] & MODE_MASK;
               s_next.mode[MD_WDL] = wd[MD_WDL];
            end
         end else if (s_reg.idx == IDX_A1CTL) begin
            s_next.a1_flag = s_reg.a1_flag & wd[C1_FLAG];
            s_next.a1_run  = wd[C1_RUN];
         end else if (s_reg.idx == IDX_A2CTL) begin
            s_next.ch_flag = s_reg.ch_flag & wd[5:0];
            s_next.im_flag = s_reg.im_flag & wd[C2_IM];
            s_next.a2_flag = s_reg.a2_flag & wd[C2_OVF];
            s_next.a2_run  = wd[C2_RUN];
            s_next.im_sel  = wd[C2_SEL +: 2];
         end else if (s_reg.idx == IDX_A2IE) begin
            s_next.ie = wd[9:0];
         end else if (s_reg.idx >= IDX_CHMODE
                      && s_reg.idx < IDX_CHMODE + 8'(NCH)) begin
            k = s_reg.idx - IDX_CHMODE;
            s_next.ch_mode[4*k +: 4] = wd[3:0];
         end else if (s_reg.idx >= IDX_CMPL
                      && s_reg.idx < IDX_CMPL + 8'(NCH)) begin
            k = s_reg.idx - IDX_CMPL;
            s_next.cmp[16*k +: 8] = wd[7:0];
            s_next.ch_mode[4*k+MM_CMP_EN] = 1'b0;
         end else if (s_reg.idx >= IDX_CMPH
                      && s_reg.idx < IDX_CMPH + 8'(NCH)) begin
            k = s_reg.idx - IDX_CMPH;
            s_next.cmp[16*k+8 +: 8] = wd[7:0];
            s_next.ch_mode[4*k+MM_CMP_EN] = 1'b1;
         end
      end
      if (a1_go) begin
         s_next.a1_cnt = s_reg.a1_cnt + 16'h1;
         if (s_reg.a1_cnt == 16'hffff)
            s_next.a1_flag = 1'b1;
      end
      if (s_reg.a2_run) begin
         s_next.a2_cnt = a2_nx;
         if (a2_wrap)
            s_next.a2_flag = 1'b1;
         if ((s_reg.a2_cnt & im_mask) == im_mask)
            s_next.im_flag = 1'b1;
      end
      for (int i = 0; i < NCH; i++) begin
         if (!s_reg.ch_mode[4*i+MM_CMP_EN]) begin
            s_next.pin[i] = 1'b0;
         end else if (ch_active[i] && s_reg.a2_run) begin
            // Looking at the next count lets compare zero stay high
            if (a2_wrap)
               s_next.pin[i] = (s_reg.cmp[16*i +: 16] == 16'h0);
            else if (a2_nx == s_reg.cmp[16*i +: 16])
               s_next.pin[i] = 1'b1;
            if (a2_nx == s_reg.cmp[16*i +: 16]
                && s_reg.ch_mode[4*i+MM_MATCH])
               s_next.ch_flag[i] = 1'b1;
         end
      end
      s_next.wr_pend = acc & hwrite;
      if (acc)
         s_next.idx = a_idx;
      if (acc & ~hwrite)
         s_next.rdata = rd_word(s_reg, a_idx);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
         s_reg.mode <= MODE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s_reg.rdata;
   assign watchdog_active    = s_reg.mode[MD_WDE];
   assign channel_output_pin = s_reg.pin;
   assign array1_irq = s_reg.a1_flag & s_reg.mode[MD_OIE];
   assign array2_irq = s_reg.ie[IE_GLOBAL] & s_reg.ie[IE_GATE]
                     & (|(s_reg.ch_flag & s_reg.ie[5:0])
                        | (s_reg.im_flag & s_reg.ie[IE_IM])
                        | (s_reg.a2_flag & s_reg.ie[IE_OVF]));

   a_lock_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.mode[MD_WDL] && s_reg.mode[MD_WDE] |=> s_reg.mode[MD_WDE])
      else $error("watchdog enable cleared while locked");

   a_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.wr_pend && s_reg.idx == IDX_MODE |=> !s_reg.mode[4])
      else $error("unused mode bit became set");

   a_mode_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.mode[MD_WDE] |=> {s_reg.mode[7], s_reg.mode[5:0]}
         == {$past(s_reg.mode[7]), $past(s_reg.mode[5:0])})
      else $error("mode bits changed while watchdog enabled");

   a_a2_overflow: assert property (@(posedge hclk) disable iff (!hresetn)
      a2_wrap |=> s_reg.a2_flag && s_reg.a2_cnt == 16'h0)
      else $error("overflow flag missed on wrap");

   a_pwm_off: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_reg.ch_mode[MM_CMP_EN] |=> !s_reg.pin[0])
      else $error("pin high with comparator disabled");

   a_pwm_match: assert property (@(posedge hclk) disable iff (!hresetn)
      ch_active[0] && s_reg.a2_run && !a2_wrap
      && a2_nx == s_reg.cmp[15:0] |=> s_reg.pin[0] && s_reg.a2_cnt
         == s_reg.cmp[15:0])
      else $error("pin not high after match");

   a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      array2_irq |-> s_reg.ie[IE_GLOBAL] && s_reg.ie[IE_GATE])
      else $error("array2 request without both gates");

   a_a1_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      a1_go && s_reg.a1_cnt == 16'hffff && s_reg.mode[MD_OIE]
      && !(s_reg.wr_pend && s_reg.idx == IDX_MODE) |=> array1_irq)
      else $error("overflow request not raised");

   a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.a2_flag && !(s_reg.wr_pend && s_reg.idx == IDX_A2CTL)
      |=> s_reg.a2_flag)
      else $error("overflow flag dropped without software");

   a_low_clears: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.wr_pend && s_reg.idx == IDX_CMPL |=> !s_reg.ch_mode[MM_CMP_EN])
      else $error("low byte write left comparator enabled");

endmodule : cap_top

/* bench/cap_pins_model.sv */
// Purpose: Far-side pins, the external count input and external oscillator
// Assumes: Bursts are asked for by the bench, one at a time
// Notes: Both lines rest high between bursts so no stray edge is counted
`timescale 1ns/100ps
module cap_pins_model (
   input  wire logic hclk,
   output      logic count_pin,
   output      logic osc_pin
);
   initial begin
      count_pin = 1'b1;
      osc_pin   = 1'b1;
   end
   // Six-cycle period, well under sysclk/4
   task automatic burst(input int n, input bit use_osc);
      for (int k = 0; k < 2 * n; k++) begin
         repeat (3) @(posedge hclk);
         if (use_osc) osc_pin <= ~osc_pin;
         else count_pin <= ~count_pin;
      end
   endtask : burst
endmodule : cap_pins_model

/* bench/tb_counter_array_pwm_irq.sv */
// Purpose: Self-checking bench for the counter array block
// Assumes: Zero wait state slave, hready looped from hreadyout
// Notes: One full array2 wrap is run, so the run is about 67k cycles
`timescale 1ns/100ps
module tb_counter_array_pwm_irq;
   import cap_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, cpu_idle, force_idle;
   logic        timer0_ovf, timer4_ovf, timer5_ovf, hreadyout, hresp;
   logic        array1_irq, array2_irq, watchdog_active, cnt_pin, osc_pin;
   logic [31:0] haddr, hwdata, hrdata, r, d;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [5:0]  channel_output_pin;
   logic [15:0] cmp;
   wire  logic  hready;
   int          fails, check_count, cyc;
   integer      seed;
   assign hready = hreadyout;

   cap_top u_cap_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .cpu_idle(cpu_idle),
      .timer0_ovf(timer0_ovf), .timer4_ovf(timer4_ovf),
      .timer5_ovf(timer5_ovf), .external_count_input(cnt_pin),
      .ext_osc(osc_pin), .array1_irq(array1_irq),
      .array2_irq(array2_irq), .watchdog_active(watchdog_active),
      .channel_output_pin(channel_output_pin));
   cap_pins_model u_cap_pins_model (.hclk(hclk), .count_pin(cnt_pin),
      .osc_pin(osc_pin));

   initial hclk = 1'b0;
   always #50 hclk = ~hclk;

   // Timer pulses at fixed spacing so 48-cycle spans give exact counts
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      timer0_ovf <= (cyc % 3 == 0);
      timer4_ovf <= (cyc % 6 == 0);
      timer5_ovf <= (cyc % 12 == 0);
      cpu_idle <= force_idle | 1'($random(seed));
      if (cyc == 90000) begin
         fails++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test

   task automatic check(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic ahb(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb

   // Counts gained by the first array over one measured span
   task automatic span(input int kind, output logic [31:0] dl);
      logic [31:0] a, b;
      ahb(1'b0, IDX_A1CNT, 32'h0, a);
      if (kind == 1) u_cap_pins_model.burst(16, 1'b0);
      if (kind == 2) u_cap_pins_model.burst(64, 1'b1);
      if (kind != 0) repeat (6) @(posedge hclk);
      else repeat (45) @(posedge hclk);
      ahb(1'b0, IDX_A1CNT, 32'h0, b);
      dl = {16'h0, b[15:0] - a[15:0]};
   endtask : span

   function automatic logic [31:0] exp_delta(input logic [2:0] code);
      case (code)
         TB_DIV12: return 32'h4;
         TB_DIV4:  return 32'hc;
         TB_T0:    return 32'h10;
         TB_SYS:   return 32'h30;
         TB_T4:    return 32'h8;
         TB_ECI:   return 32'h10;
         default:  return 32'h8 >> (code == TB_T5);
      endcase
   endfunction : exp_delta

   initial begin
      seed = 32'hafd2c905;
      {hsel, hwrite, htrans, haddr, hwdata, cyc, force_idle} = '0;
      {timer0_ovf, timer4_ovf, timer5_ovf, cpu_idle} = '0;
      hsize = 3'b010;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, IDX_MODE, 32'h0, r);
      check("mode reset", 32'h40, r);
      ahb(1'b1, IDX_MODE, 32'hff, r);
      ahb(1'b0, IDX_MODE, 32'h0, r);
      check("mode guarded", 32'h40, r);
      ahb(1'b1, IDX_MODE, 32'h0, r);
      @(negedge hclk);
      check("watchdog off", 32'h0, {31'h0, watchdog_active});
      $display("test mode guard done");
      ahb(1'b1, IDX_A1CTL, 32'h40, r);
      for (int c = 0; c < 8; c++) begin
         ahb(1'b1, IDX_MODE, {28'h0, c[2:0], 1'b0}, r);
         span(c == 3 ? 1 : (c == 5 ? 2 : 0), d);
         check("timebase span", exp_delta(c[2:0]), d);
      end
      ahb(1'b1, IDX_MODE, 32'h88, r);
      force_idle = 1'b1;
      span(0, d);
      check("idle span", 32'h0, d);
      force_idle = 1'b0;
      $display("test timebase done");
      cmp = 16'd64 + 16'($random(seed) & 32'h3ff);
      ahb(1'b1, IDX_MODE, 32'h09, r);
      ahb(1'b1, IDX_CHMODE, 32'hf, r);
      ahb(1'b1, IDX_CHMODE + 8'h1, 32'h3, r);
      ahb(1'b1, IDX_CHMODE + 8'h2, 32'h7, r);
      ahb(1'b1, IDX_CHMODE + 8'h3, 32'h7, r);
      for (int ch = 0; ch < 4; ch++) begin
         d = (ch == 3) ? 32'h0 : {16'h0, cmp};
         ahb(1'b1, IDX_CMPL + 8'(ch), {24'h0, d[7:0]}, r);
         ahb(1'b1, IDX_CMPH + 8'(ch), {24'h0, d[15:8]}, r);
      end
      ahb(1'b1, IDX_CMPL + 8'h2, {24'h0, cmp[7:0]}, r);
      ahb(1'b0, IDX_CHMODE + 8'h2, 32'h0, r);
      check("low write mode", 32'h6, r);
      ahb(1'b0, IDX_CHMODE, 32'h0, r);
      check("high write mode", 32'hf, r);
      ahb(1'b1, IDX_A2IE, 32'h180, r);
      ahb(1'b1, IDX_A2CTL, 32'h1ff, r);
      repeat (cmp - 4) @(negedge hclk);
      check("pins before match", 32'h0, {26'h0, channel_output_pin});
      repeat (8) @(negedge hclk);
      check("pins after match", 32'h1, {26'h0, channel_output_pin});
      repeat (65560 - cmp) @(negedge hclk);
      check("pins after wrap", 32'h8, {26'h0, channel_output_pin});
      ahb(1'b0, IDX_A2CTL, 32'h0, r);
      check("array2 flags", 32'h1c1, r);
      check("irq no global", 32'h0, {31'h0, array2_irq});
      ahb(1'b1, IDX_A2IE, 32'h380, r);
      @(negedge hclk);
      check("irq gated on", 32'h1, {31'h0, array2_irq});
      ahb(1'b1, IDX_A2IE, 32'h300, r);
      @(negedge hclk);
      check("irq masked", 32'h0, {31'h0, array2_irq});
      ahb(1'b1, IDX_A2IE, 32'h301, r);
      @(negedge hclk);
      check("irq channel", 32'h1, {31'h0, array2_irq});
      check("array1 irq", 32'h1, {31'h0, array1_irq});
      ahb(1'b0, IDX_A1CTL, 32'h0, r);
      check("array1 flag", 32'hc0, r);
      ahb(1'b1, IDX_A1CTL, 32'h40, r);
      @(negedge hclk);
      check("array1 irq clear", 32'h0, {31'h0, array1_irq});
      $display("test pwm and flags done");
      ahb(1'b1, IDX_MODE, 32'h3f, r);
      ahb(1'b0, IDX_MODE, 32'h0, r);
      check("mode unused bit", 32'h2f, r);
      ahb(1'b1, IDX_MODE, 32'h6f, r);
      ahb(1'b1, IDX_MODE, 32'h0, r);
      ahb(1'b0, IDX_MODE, 32'h0, r);
      check("mode locked", 32'h6f, r);
      check("watchdog on", 32'h1, {31'h0, watchdog_active});
      $display("test watchdog lock done");
      finish_test();
   end
endmodule : tb_counter_array_pwm_irq
